// >>> hw/asi_pkg.sv
// constants, register layouts and state codes of the async serial interface
// assumes an 8-bit register port with a 3-bit address, single bus clock
package asi_pkg;
    localparam logic [2:0] ASI_OFS_DATA = 3'h0;
    localparam logic [2:0] ASI_OFS_CTRL_ONE = 3'h1;
    localparam logic [2:0] ASI_OFS_CTRL_TWO = 3'h2;
    localparam logic [2:0] ASI_OFS_STATUS = 3'h3;
    localparam logic [2:0] ASI_OFS_RATE = 3'h4;
    localparam logic [7:0] ASI_RST_CTRL = 8'h00;
    localparam logic [7:0] ASI_RST_STATUS = 8'hc0;
    localparam logic [7:0] ASI_RST_RATE = 8'h00;
    localparam logic [7:0] ASI_RST_DATA = 8'h00;
    // shared prescaler divisors, one per prescale code
    localparam logic [3:0] ASI_PRE_DIV_0 = 4'h1;
    localparam logic [3:0] ASI_PRE_DIV_1 = 4'h3;
    localparam logic [3:0] ASI_PRE_DIV_2 = 4'h5;
    localparam logic [3:0] ASI_PRE_DIV_3 = 4'h7;
    localparam logic [3:0] ASI_SUB_LAST = 4'hf;
    localparam logic [4:0] ASI_RT_FIRST = 5'h01;
    localparam logic [4:0] ASI_RT_AFTER_EDGE = 5'h02;
    localparam logic [4:0] ASI_RT_VER_A = 5'h03;
    localparam logic [4:0] ASI_RT_VER_B = 5'h05;
    localparam logic [4:0] ASI_RT_VER_C = 5'h07;
    localparam logic [4:0] ASI_RT_VOTE_A = 5'h08;
    localparam logic [4:0] ASI_RT_VOTE_B = 5'h09;
    localparam logic [4:0] ASI_RT_VOTE_C = 5'h0a;
    localparam logic [4:0] ASI_RT_LAST = 5'h10;
    localparam logic [3:0] ASI_FRAME_LEN_8 = 4'ha;
    localparam logic [3:0] ASI_FRAME_LEN_9 = 4'hb;

    typedef struct packed {
        logic rx_bit8;
        logic tx_bit8;
        logic unused5;
        logic word_nine;
        logic wake_addr;
        logic clk_pol;
        logic clk_pha;
        logic last_clk;
    } asi_ctrl_one_t;

    typedef struct packed {
        logic tx_empty_ie;
        logic tx_done_irq_enable;
        logic rx_ie;
        logic idle_ie;
        logic tx_on_bit;
        logic rx_on_bit;
        logic receiver_sleep_bit;
        logic break_send_bit;
    } asi_ctrl_two_t;

    typedef struct packed {
        logic tx_buffer_empty_flag;
        logic transmit_complete_flag;
        logic rx_buffer_full_flag;
        logic idle_flag;
        logic overrun_flag;
        logic noise_flag;
        logic framing_error_flag;
        logic unused0;
    } asi_status_t;

    typedef struct packed {
        logic shared_prescale_high;
        logic shared_prescale_low;
        logic [2:0] tx_rate_select;
        logic [2:0] rx_rate_select;
    } asi_rate_t;

    typedef enum logic [1:0] {
        TX_IDLE = 2'b00,
        TX_DATA = 2'b01,
        TX_PRE = 2'b10,
        TX_BRK = 2'b11
    } asi_tx_state_t;

    typedef enum logic {
        RX_IDLE = 1'b0,
        RX_FRAME = 1'b1
    } asi_rx_state_t;
endpackage : asi_pkg

// >>> hw/asi_serial_interface.sv
// full-duplex async serial interface: rate generator, transmitter with shift clock,
// oversampling receiver, register port
// assumes synchronous inputs and a master that never waits for the slave
// How it works
// R1: transmitter and receiver run independently, own rate selects, shared prescaler and format.
// R2: frame is low start, eight or nine data bits, high stop; line idles high.
// R3: data bits go out and come in least significant bit first.
// R4: shift clock pulses only on data bits; last-bit option, polarity and phase selectable.
// R5: data write starts sending; load into shifter on bit clock sets buffer-empty flag.
// R6: character done with nothing pending sets transmit-complete flag.
// R7: transmitter disabled after shifter drained also sets transmit-complete flag.
// R8: disabling mid-character finishes that character before releasing the output pin.
// R9: received character moved to data register on rx clock sets buffer-full flag.
// R10: data register read returns last received character while receiver enabled.
// R11: status holds overrun, noise and framing error flags of received characters.
// R12: idle flag only after a valid character since the previous idle.
// R13: two prescaler bits plus two three-bit selectors give thirty-two rates.
// R14: any transmit rate allows all eight receive rates.
// R15: transmitter has a fixed divide-by-16 matching receiver oversampling.
// R16: software should change rates only with both directions disabled.
// R17: break is a whole frame of zeros, ten or eleven bits.
// R18: noise as short as one sixteenth bit time is caught by the noise flag if it hits a sample tick (3, 5, 7 of the start bit, 8, 9, 10 of any bit).
// R19: one data address: writes go to transmit buffer, reads from receive buffer.
// R20: control one holds wake method and word length; control two enables, sleep, break.
// R21: sixteen ticks per bit, majority of ticks 8, 9, 10, noise on disagreement.
// R22: start edge verified by three samples, two zeros accept, any one flags noise.
// R23: sleeping receiver sets no receive flags; hardware clears sleep on wake.
// R24: sleeper wakes on a full idle frame or on a character with top bit set.
// R25: break bit sends zero frames after current character, then line returns high.
module asi_serial_interface
    import asi_pkg::*;
(
    input wire logic clock_in,
    input wire logic rst_b_in,
    input wire logic [2:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [7:0] rdata_out,
    output logic irq_out,
    input wire logic serial_in_pin,
    output logic tx_out,
    output logic tx_oe_b_out,
    output logic sclk_out,
    output logic sclk_oe_b_out
);
    asi_ctrl_one_t c1;
    asi_ctrl_two_t c2;
    asi_status_t st;
    asi_rate_t rate;
    logic [7:0] tdr;
    logic [7:0] rdr;
    logic st_armed;
    logic pre_pend;

    // rate generator
    logic [3:0] pre_div;
    logic [3:0] pre_cnt;
    logic pre_tick;
    logic [6:0] rate_cnt;
    logic [6:0] rx_mask;
    logic [6:0] tx_mask;
    logic rx_rt_tick;
    logic tx_rt_tick;
    logic [3:0] tx_sub;
    logic tx_bit_tick;

    always_comb begin
        unique case ({rate.shared_prescale_high, rate.shared_prescale_low})
            2'b00: pre_div = ASI_PRE_DIV_0;
            2'b01: pre_div = ASI_PRE_DIV_1;
            2'b10: pre_div = ASI_PRE_DIV_2;
            2'b11: pre_div = ASI_PRE_DIV_3;
        endcase
    end

    assign pre_tick = (pre_cnt == pre_div - 4'h1); // R13
    assign rx_mask = 7'((8'h01 << rate.rx_rate_select) - 8'h01); // R14
    assign tx_mask = 7'((8'h01 << rate.tx_rate_select) - 8'h01);
    assign rx_rt_tick = pre_tick && ((rate_cnt & rx_mask) == rx_mask); // R1
    assign tx_rt_tick = pre_tick && ((rate_cnt & tx_mask) == tx_mask);
    assign tx_bit_tick = tx_rt_tick && (tx_sub == ASI_SUB_LAST); // R15

    // rates change glitchlessly only if both directions are off
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            pre_cnt <= 4'h0;
            rate_cnt <= 7'h00;
            tx_sub <= 4'h0;
        end else begin
            pre_cnt <= pre_tick ? 4'h0 : pre_cnt + 4'h1;
            if (pre_tick) begin
                rate_cnt <= rate_cnt + 7'h01;
            end
            if (tx_rt_tick) begin
                tx_sub <= tx_sub + 4'h1;
            end
        end
    end

    // transmitter
    asi_tx_state_t tx_state;
    asi_tx_state_t next_kind;
    logic [10:0] frame_sr;
    logic [3:0] tx_idx;
    logic [3:0] tx_last;
    logic frame_end;
    logic tx_step;
    logic tx_load;
    logic sclk_en;

    always_comb begin
        if (!c2.tx_on_bit) begin
            next_kind = TX_IDLE; // R8
        end else if (pre_pend) begin
            next_kind = TX_PRE;
        end else if (!st.tx_buffer_empty_flag) begin
            next_kind = TX_DATA;
        end else if (c2.break_send_bit) begin
            next_kind = TX_BRK; // R25
        end else begin
            next_kind = TX_IDLE;
        end
    end

    assign frame_end = tx_bit_tick && (tx_state != TX_IDLE) && (tx_idx == tx_last);
    assign tx_step = tx_bit_tick && ((tx_state == TX_IDLE) || frame_end);
    assign tx_load = tx_step && (next_kind == TX_DATA); // R5
    assign sclk_en = (tx_state == TX_DATA) && (tx_idx != 4'h0) && (tx_idx < tx_last)
        && ((tx_idx != tx_last - 4'h1) || c1.last_clk); // R4

    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            tx_state <= TX_IDLE;
            frame_sr <= 11'h7ff;
            tx_idx <= 4'h0;
            tx_last <= ASI_FRAME_LEN_8 - 4'h1;
        end else if (tx_step) begin
            tx_state <= next_kind;
            tx_idx <= 4'h0;
            tx_last <= (c1.word_nine ? ASI_FRAME_LEN_9 : ASI_FRAME_LEN_8) - 4'h1; // R17
            unique case (next_kind)
                TX_DATA: frame_sr <= c1.word_nine ? {1'b1, c1.tx_bit8, tdr, 1'b0}
                    : {2'b11, tdr, 1'b0}; // R2
                TX_PRE: frame_sr <= 11'h7ff;
                TX_BRK: frame_sr <= 11'h000; // R25
                TX_IDLE: frame_sr <= 11'h7ff;
            endcase
        end else if (tx_bit_tick && tx_state != TX_IDLE) begin
            frame_sr <= {1'b1, frame_sr[10:1]}; // R3
            tx_idx <= tx_idx + 4'h1;
        end
    end

    // pins: enable low while driving; shifter keeps the pin until its frame ends
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            tx_out <= 1'b1;
            tx_oe_b_out <= 1'b1;
            sclk_out <= 1'b0;
            sclk_oe_b_out <= 1'b1;
        end else begin
            tx_out <= (tx_state == TX_IDLE) ? 1'b1 : frame_sr[0];
            tx_oe_b_out <= !(c2.tx_on_bit || tx_state != TX_IDLE); // R8
            sclk_oe_b_out <= !(c2.tx_on_bit || tx_state != TX_IDLE);
            sclk_out <= c1.clk_pol ^ (sclk_en & (tx_sub[3] ^ c1.clk_pha)); // R4
        end
    end

    // receiver
    asi_rx_state_t rx_state;
    logic [4:0] rx_rt;
    logic [3:0] rx_bit;
    logic [3:0] rx_last;
    logic [1:0] zeros;
    logic [1:0] zsum;
    logic v8;
    logic v9;
    logic maj;
    logic disagree;
    logic fnoise;
    logic armed;
    logic [8:0] rx_sr;
    logic rx_done;
    logic rx_accept;
    logic wake_now;
    logic [7:0] idle_cnt;
    logic [7:0] idle_target;
    logic idle_evt;
    logic char_seen;

    assign rx_last = (c1.word_nine ? ASI_FRAME_LEN_9 : ASI_FRAME_LEN_8) - 4'h1;
    assign zsum = zeros + {1'b0, !serial_in_pin};
    assign maj = (v8 & v9) | (v8 & serial_in_pin) | (v9 & serial_in_pin); // R21
    assign disagree = !((v8 == v9) && (v9 == serial_in_pin));
    assign rx_done = rx_rt_tick && (rx_state == RX_FRAME) && (rx_rt == ASI_RT_VOTE_C)
        && (rx_bit == rx_last);
    assign wake_now = c2.receiver_sleep_bit && c1.wake_addr && rx_sr[8]; // R24
    assign rx_accept = rx_done && (!c2.receiver_sleep_bit || wake_now); // R23
    assign idle_target = {c1.word_nine ? ASI_FRAME_LEN_9 : ASI_FRAME_LEN_8, 4'h0};
    assign idle_evt = rx_rt_tick && c2.rx_on_bit && (rx_state == RX_IDLE) && serial_in_pin
        && (idle_cnt == idle_target - 8'h01);

    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rx_state <= RX_IDLE;
            rx_rt <= ASI_RT_FIRST;
            rx_bit <= 4'h0;
            zeros <= 2'h0;
            v8 <= 1'b1;
            v9 <= 1'b1;
            fnoise <= 1'b0;
            armed <= 1'b0;
            rx_sr <= 9'h000;
        end else if (!c2.rx_on_bit) begin
            rx_state <= RX_IDLE;
            armed <= 1'b0;
        end else if (rx_rt_tick) begin
            unique case (rx_state)
                RX_IDLE: begin
                    armed <= serial_in_pin;
                    if (armed && !serial_in_pin) begin
                        rx_state <= RX_FRAME;
                        rx_rt <= ASI_RT_AFTER_EDGE;
                        rx_bit <= 4'h0;
                        zeros <= 2'h0;
                        fnoise <= 1'b0;
                    end
                end
                RX_FRAME: begin
                    rx_rt <= rx_rt + 5'h01;
                    if (rx_bit == 4'h0 && (rx_rt == ASI_RT_VER_A || rx_rt == ASI_RT_VER_B
                        || rx_rt == ASI_RT_VER_C)) begin
                        zeros <= zsum; // R22
                        if (serial_in_pin) begin
                            fnoise <= 1'b1; // R22
                        end
                        if (rx_rt == ASI_RT_VER_C && zsum < 2'h2) begin
                            rx_state <= RX_IDLE;
                        end
                    end
                    if (rx_rt == ASI_RT_VOTE_A) begin
                        v8 <= serial_in_pin;
                    end
                    if (rx_rt == ASI_RT_VOTE_B) begin
                        v9 <= serial_in_pin;
                    end
                    if (rx_rt == ASI_RT_VOTE_C) begin
                        if (disagree) begin
                            fnoise <= 1'b1; // R18
                        end
                        if (rx_bit == 4'h0 && maj) begin
                            rx_state <= RX_IDLE;
                        end else if (rx_bit == rx_last) begin
                            rx_state <= RX_IDLE;
                            armed <= maj; // after a break the line must go high first
                        end else if (rx_bit != 4'h0) begin
                            rx_sr <= {maj, rx_sr[8:1]}; // R3
                        end
                    end
                    if (rx_rt == ASI_RT_LAST) begin
                        rx_rt <= ASI_RT_FIRST;
                        rx_bit <= rx_bit + 4'h1;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            idle_cnt <= 8'h00;
            char_seen <= 1'b0;
        end else begin
            if (rx_state != RX_IDLE || !c2.rx_on_bit) begin
                idle_cnt <= 8'h00;
            end else if (rx_rt_tick) begin
                if (!serial_in_pin) begin
                    idle_cnt <= 8'h00;
                end else if (idle_cnt != idle_target) begin
                    idle_cnt <= idle_cnt + 8'h01;
                end
            end
            if (rx_accept) begin
                char_seen <= 1'b1;
            end else if (idle_evt) begin
                char_seen <= 1'b0; // R12
            end
        end
    end

    // register port
    logic rd_data;
    logic wr_data;
    assign rd_data = rd_in && (addr_in == ASI_OFS_DATA);
    assign wr_data = wr_in && (addr_in == ASI_OFS_DATA);

    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            c1 <= ASI_RST_CTRL;
            c2 <= ASI_RST_CTRL;
            rate <= ASI_RST_RATE;
            tdr <= ASI_RST_DATA;
        end else begin
            if (wr_data) begin
                tdr <= wdata_in; // R19
            end
            if (wr_in && addr_in == ASI_OFS_CTRL_ONE) begin
                c1 <= {c1.rx_bit8, wdata_in[6:0]}; // R20
            end else if (rx_accept && c1.word_nine) begin
                c1.rx_bit8 <= rx_sr[8];
            end
            if (wr_in && addr_in == ASI_OFS_CTRL_TWO) begin
                c2 <= wdata_in; // R20
            end else if ((rx_done && wake_now)
                || (idle_evt && c2.receiver_sleep_bit && !c1.wake_addr)) begin
                c2.receiver_sleep_bit <= 1'b0; // R24
            end
            if (wr_in && addr_in == ASI_OFS_RATE) begin
                rate <= wdata_in; // R16
            end
        end
    end

    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            pre_pend <= 1'b0;
        end else if (wr_in && addr_in == ASI_OFS_CTRL_TWO && wdata_in[3] && !c2.tx_on_bit) begin
            pre_pend <= 1'b1;
        end else if (tx_step && next_kind == TX_PRE) begin
            pre_pend <= 1'b0;
        end
    end

    // flags: hardware set wins over a clear in the same cycle
    logic clr_rx;
    assign clr_rx = rd_data && st_armed;

    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            st <= ASI_RST_STATUS;
            rdr <= ASI_RST_DATA;
            st_armed <= 1'b0;
        end else begin
            if (rd_in && addr_in == ASI_OFS_STATUS) begin
                st_armed <= 1'b1;
            end else if (rd_data || wr_data) begin
                st_armed <= 1'b0;
            end
            st.tx_buffer_empty_flag <= tx_load || (st.tx_buffer_empty_flag && !wr_data); // R5
            st.transmit_complete_flag <= (frame_end && next_kind == TX_IDLE)
                || (st.transmit_complete_flag && !wr_data); // R6 R7
            // a character landing on the clearing read is kept, not counted as overrun
            st.rx_buffer_full_flag <= rx_accept
                || (st.rx_buffer_full_flag && !clr_rx); // R9
            st.overrun_flag <= (rx_accept && st.rx_buffer_full_flag && !clr_rx)
                || (st.overrun_flag && !clr_rx); // R11
            st.noise_flag <= (rx_accept && (fnoise || disagree))
                || (st.noise_flag && !clr_rx); // R21
            st.framing_error_flag <= (rx_accept && !maj)
                || (st.framing_error_flag && !clr_rx); // R11
            st.idle_flag <= (idle_evt && char_seen && !c2.receiver_sleep_bit)
                || (st.idle_flag && !clr_rx); // R12
            st.unused0 <= 1'b0;
            if (rx_accept && (!st.rx_buffer_full_flag || clr_rx)) begin
                rdr <= c1.word_nine ? rx_sr[7:0] : rx_sr[8:1]; // R9
            end
        end
    end

    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rdata_out <= 8'h00;
            irq_out <= 1'b0;
        end else begin
            irq_out <= (st.tx_buffer_empty_flag && c2.tx_empty_ie)
                || (st.transmit_complete_flag && c2.tx_done_irq_enable)
                || ((st.rx_buffer_full_flag || st.overrun_flag) && c2.rx_ie)
                || (st.idle_flag && c2.idle_ie);
            rdata_out <= 8'h00;
            if (rd_in) begin
                unique case (addr_in)
                    ASI_OFS_DATA: rdata_out <= c2.rx_on_bit ? rdr : 8'h00; // R10
                    ASI_OFS_CTRL_ONE: rdata_out <= c1;
                    ASI_OFS_CTRL_TWO: rdata_out <= c2;
                    ASI_OFS_STATUS: rdata_out <= st;
                    ASI_OFS_RATE: rdata_out <= rate;
                    default: rdata_out <= 8'h00;
                endcase
            end
        end
    end

    // checks
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!rst_b_in);

    sequence s_load;
        tx_load;
    endsequence
    sequence s_start_bit;
        tx_state == TX_DATA && tx_idx == 4'h0;
    endsequence

    property p_start_low;
        s_load ##1 s_start_bit |=> !tx_out;
    endproperty
    a_start_low: assert property (p_start_low) else $error("start bit not low"); // R2

    property p_lsb_first;
        s_load |=> frame_sr[1] == $past(tdr[0]) && frame_sr[0] == 1'b0;
    endproperty
    a_lsb_first: assert property (p_lsb_first) else $error("lsb not next"); // R3

    property p_sclk_quiet;
        !sclk_en |=> sclk_out == $past(c1.clk_pol);
    endproperty
    a_sclk_quiet: assert property (p_sclk_quiet) else $error("shift clock outside data"); // R4

    property p_load_empty;
        s_load |=> st.tx_buffer_empty_flag;
    endproperty
    a_load_empty: assert property (p_load_empty) else $error("empty flag not set"); // R5

    property p_tc_set;
        frame_end && next_kind == TX_IDLE |=> st.transmit_complete_flag;
    endproperty
    a_tc_set: assert property (p_tc_set) else $error("complete flag not set"); // R6

    property p_hold_pin;
        tx_state != TX_IDLE |=> !tx_oe_b_out;
    endproperty
    a_hold_pin: assert property (p_hold_pin) else $error("pin released mid frame"); // R8

    property p_rx_full;
        rx_accept && !st.rx_buffer_full_flag |=> st.rx_buffer_full_flag
            && rdr == ($past(c1.word_nine) ? $past(rx_sr[7:0]) : $past(rx_sr[8:1]));
    endproperty
    a_rx_full: assert property (p_rx_full) else $error("receive not posted"); // R9

    property p_idle_needs_char;
        $rose(st.idle_flag) |-> $past(char_seen);
    endproperty
    a_idle_needs_char: assert property (p_idle_needs_char) else $error("idle without char"); // R12

    property p_sleep_blocks;
        c2.receiver_sleep_bit && !wake_now |=> !$rose(st.rx_buffer_full_flag);
    endproperty
    a_sleep_blocks: assert property (p_sleep_blocks) else $error("flag set while asleep"); // R23

    property p_tx_rate;
        tx_bit_tick |=> !tx_bit_tick [*8];
    endproperty
    a_tx_rate: assert property (p_tx_rate) else $error("bit ticks too close"); // R15
endmodule : asi_serial_interface

// >>> tb/asi_peer.sv
// remote serial peer: drives the receive line and captures frames from the transmit line
// assumes rate code 00, so one bit lasts 16 clock cycles
module asi_peer (
    input wire logic clock_in,
    input wire logic tx_line_in,
    output logic rx_line_out
);
    timeunit 1ns;
    timeprecision 1ps;
    initial rx_line_out = 1'b1;
    // gb selects the data bit that gets a one-clock glitch; -1 and 8 hit start and stop, values outside -1..8 mean none
    task automatic send(input logic [7:0] d, input int gb, input logic stp);
        logic [9:0] f;
        f = {stp, d, 1'b0};
        for (int b = 0; b < 10; b++) begin
            for (int t = 0; t < 16; t++) begin
                @(posedge clock_in);
                rx_line_out <= (b == gb + 1 && t == 8) ? ~f[b] : f[b];
            end
        end
        @(posedge clock_in);
        rx_line_out <= 1'b1;
    endtask : send
    // samples mid-bit; ok stays low when no start edge shows up
    task automatic catch_frame(output logic [9:0] f, output logic ok);
        ok = 1'b0;
        f = '0;
        for (int n = 0; n < 4000 && !ok; n++) begin
            @(posedge clock_in);
            ok = (tx_line_in === 1'b0);
        end
        if (ok) begin
            repeat (8) @(posedge clock_in);
            f[0] = tx_line_in;
            for (int b = 1; b < 10; b++) begin
                repeat (16) @(posedge clock_in);
                f[b] = tx_line_in;
            end
        end
    endtask : catch_frame
endmodule : asi_peer

// >>> tb/tb_asi_serial_interface.sv
// self-checking bench for the async serial interface
// assumes rate code 00 (16 clocks a bit) and the peer model in asi_peer
module tb_asi_serial_interface
    import asi_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock_in = 1'b0;
    logic rst_b_in = 1'b0;
    logic [2:0] addr_in = '0;
    logic [7:0] wdata_in = '0;
    logic wr_in = 1'b0;
    logic rd_in = 1'b0;
    logic [7:0] rdata_out, st, d;
    logic irq_out, serial_in_pin, tx_out, tx_oe_b_out, sclk_out, sclk_oe_b_out;
    int err_count = 0;
    int total_checks = 0;
    int sclk_rises = 0;
    logic sclk_q = 1'b0;
    always #5 clock_in = ~clock_in;
    // counts shift clock rising edges for the pulse-count check
    always @(posedge clock_in) begin
        sclk_q <= sclk_out;
        if (sclk_out && !sclk_q) sclk_rises++;
    end
    asi_serial_interface u_dut (.clock_in(clock_in), .rst_b_in(rst_b_in), .addr_in(addr_in),
        .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
        .irq_out(irq_out), .serial_in_pin(serial_in_pin), .tx_out(tx_out),
        .tx_oe_b_out(tx_oe_b_out), .sclk_out(sclk_out), .sclk_oe_b_out(sclk_oe_b_out));
    asi_peer u_peer (.clock_in(clock_in), .tx_line_in(tx_out), .rx_line_out(serial_in_pin));
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : tally_and_finish
    task automatic check(input logic [9:0] seen, input logic [9:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic wr(input logic [2:0] a, input logic [7:0] v);
        @(posedge clock_in);
        wr_in <= 1'b1;
        addr_in <= a;
        wdata_in <= v;
        @(posedge clock_in);
        wr_in <= 1'b0;
    endtask : wr
    // read data stands only in the cycle after the strobe
    task automatic rd(input logic [2:0] a, output logic [7:0] v);
        @(posedge clock_in);
        rd_in <= 1'b1;
        addr_in <= a;
        @(posedge clock_in);
        rd_in <= 1'b0;
        #1 v = rdata_out;
    endtask : rd
    task automatic wait_flag(input logic [7:0] mask);
        for (int n = 0; n < 300; n++) begin
            rd(ASI_OFS_STATUS, st);
            if ((st & mask) != 8'h00) return;
        end
        err_count++;
        tally_and_finish();
    endtask : wait_flag
    task automatic t_reset_values();
        check(tx_oe_b_out, 1'b1);
        check(sclk_oe_b_out, 1'b1);
        check(irq_out, 1'b0);
        rd(ASI_OFS_STATUS, d);
        check(d, ASI_RST_STATUS);
        rd(ASI_OFS_CTRL_TWO, d);
        check(d, ASI_RST_CTRL);
        rd(ASI_OFS_RATE, d);
        check(d, ASI_RST_RATE);
        wr(ASI_OFS_RATE, 8'h00);
        rd(3'h6, d);
        check(d, 8'h00);
    endtask : t_reset_values
    task automatic t_transmit();
        logic [9:0] f;
        logic ok;
        int s0;
        s0 = sclk_rises;
        wr(ASI_OFS_CTRL_TWO, 8'h0c);
        wr(ASI_OFS_DATA, 8'ha5);
        u_peer.catch_frame(f, ok);
        if (!ok) begin
            err_count++;
            tally_and_finish();
        end
        check(f, {1'b1, 8'ha5, 1'b0});
        check(tx_oe_b_out, 1'b0);
        check(sclk_oe_b_out, 1'b0);
        repeat (24) @(posedge clock_in);
        rd(ASI_OFS_STATUS, d);
        check(d & 8'hc0, 8'hc0);
        // eight data bits, no pulse on the last one without the option
        check(10'(sclk_rises - s0), 10'h007);
        wr(ASI_OFS_CTRL_TWO, 8'h4c);
        @(posedge clock_in);
        #1 check(irq_out, 1'b1);
        wr(ASI_OFS_CTRL_TWO, 8'h0c);
    endtask : t_transmit
    // one frame in; gb picks a glitched bit, stp the stop level
    task automatic t_receive(input logic [7:0] v, input int gb, input logic stp,
                             input logic [7:0] exp_st);
        u_peer.send(v, gb, stp);
        wait_flag(8'h22);
        check(st & 8'h26, exp_st);
        rd(ASI_OFS_DATA, d);
        check(d, v);
        repeat (40) @(posedge clock_in);
    endtask : t_receive
    initial begin
        repeat (16) @(posedge clock_in);
        rst_b_in <= 1'b1;
        t_reset_values();
        t_transmit();
        t_receive(8'h3c, -2, 1'b1, 8'h20);
        t_receive(8'h96, 3, 1'b1, 8'h24);
        // a bad stop bit still posts the character, with the framing flag
        t_receive(8'h5a, -2, 1'b0, 8'h22);
        tally_and_finish();
    end
endmodule : tb_asi_serial_interface
